/* hw/bus_node_error_logger.sv */
`include "bus_node_params.svh"
`timescale 1ns/10ps
`default_nettype none

module bus_node_error_logger #(
    parameter logic [7:0]  TYPE_CODE = 8'h37,  // Arbitrary value
    parameter logic [15:0] REVISION  = 16'h0001 // Arbitrary value
) (
    input  wire logic                      mclk_i,
    input  wire logic                      rst_i,
    input  wire bus_node_pkg::node_class_t node_class_i,
    input  wire bus_node_pkg::csr_req_t    csr_i,
    input  wire bus_node_pkg::bus_evt_t    evt_i,
    input  wire logic [3:0]                cmdr_id_i,
    input  wire logic                      local_err_i,
    input  wire logic                      selftest_i,
    output logic [31:0]                    rdata_o,
    output logic                           rvalid_o,
    output logic                           err_line_o,
    output logic                           capture_lock_o,
    output logic [3:0]                     fail_cmdr_o
);
    import bus_node_pkg::*;

    logic [31:0] ident_q, ident_d;
    logic [31:0] flags_q, flags_d;
    logic [3:0]  cmdr_q, cmdr_d;
    logic        lock_q, lock_d;
    logic [31:0] rdata_q, rdata_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] set_vec;
    logic        is_proc, is_mem, is_io;

    function automatic logic hit(input logic [11:0] ofs, input logic [11:0] target);
        hit = (ofs == target);
    endfunction

    assign is_proc = (node_class_i == CLASS_PROC);
    assign is_mem  = (node_class_i == CLASS_MEM);
    assign is_io   = (node_class_i == CLASS_IO);

    // Per-class gating: unimplemented bits never set
    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[`BE_CTRL_CHK]   = evt_i.ctrl_chk & ~is_mem;
        set_vec[`BE_DATA_CHK]   = evt_i.data_chk & ~is_mem;
        set_vec[`BE_DIRTY]      = evt_i.dirty & ~is_io;
        set_vec[`BE_SHARED]     = evt_i.shared & is_proc;
        set_vec[`BE_CMD_ADDR]   = evt_i.cmd_addr;
        set_vec[`BE_NO_CONFIRM] = evt_i.no_confirm & ~is_mem;
        set_vec[`BE_CONFIRM]    = evt_i.confirm;
        set_vec[`BE_STALL]      = evt_i.stall;
        set_vec[`BE_DRIVE_ERR]  = evt_i.drive_err;
    end

    // Identity: whole word writable by CSR; self-test loads revision, class bits and code
    always_comb begin
        ident_d = ident_q;
        if (csr_i.wr && hit(csr_i.ofs, `OFS_NODE_IDENTITY)) begin
            ident_d = csr_i.wdata;
        end
        // Self-test last, so a stray write cannot spoil the loaded identity
        if (selftest_i) begin
            ident_d[`ID_REV_HI:`ID_REV_LO] = REVISION;
            ident_d[15:0] = 16'h0000;
            ident_d[`ID_CLASS_PROC] = is_proc;
            ident_d[`ID_CLASS_MEM]  = is_mem;
            ident_d[`ID_CLASS_IO]   = is_io;
            ident_d[`ID_CODE_HI:`ID_CODE_LO] = TYPE_CODE;
        end
    end

    // Flags: W1C clear first, hardware set after so set wins
    always_comb begin
        flags_d = flags_q;
        cmdr_d  = cmdr_q;
        lock_d  = lock_q;
        if (csr_i.wr && hit(csr_i.ofs, `OFS_BUS_ERROR_FLAGS)) begin
            flags_d = flags_q & ~(csr_i.wdata & `BE_W1C_MASK);
        end
        flags_d = flags_d | set_vec;
        flags_d[`BE_LOCAL_SUM] = local_err_i;
        flags_d[31:19] = 13'h0000;
        if (|set_vec && (flags_q & `BE_W1C_MASK) == 32'h0000_0000) begin
            cmdr_d = cmdr_id_i;
        end
        // I/O node locks capture on drive error until the flag is cleared
        lock_d = is_io & flags_d[`BE_DRIVE_ERR];
    end

    // Read path, one cycle latency
    always_comb begin
        rdata_d  = 32'h0000_0000;
        rvalid_d = csr_i.rd;
        if (csr_i.rd && hit(csr_i.ofs, `OFS_NODE_IDENTITY)) begin
            rdata_d = ident_q;
        end else if (csr_i.rd && hit(csr_i.ofs, `OFS_BUS_ERROR_FLAGS)) begin
            rdata_d = flags_q;
        end
    end

    // Identity register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ident_q  <= `ID_RESET;
        end else begin
            ident_q  <= ident_d;
        end
    end

    // Flags, commander id and lock clear together on reset; the commander id outlives a W1C clear of its flags
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_q  <= `BE_RESET;
            cmdr_q   <= 4'h0;
            lock_q   <= 1'b0;
        end else begin
            flags_q  <= flags_d;
            cmdr_q   <= cmdr_d;
            lock_q   <= lock_d;
        end
    end

    // Read answer
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // I/O nodes report drive error by capture lock, not by the line
    logic pulse_req;
    assign pulse_req = |(set_vec & ~(32'(is_io) << `BE_DRIVE_ERR));

    err_pulse u_pulse (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .any_set_i  (pulse_req),
        .err_line_o (err_line_o)
    );

    assign rdata_o        = rdata_q;
    assign rvalid_o       = rvalid_q;
    assign capture_lock_o = lock_q;
    assign fail_cmdr_o    = cmdr_q;

    // Checks
    flag_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (flags_q[`BE_STALL] && !(csr_i.wr && hit(csr_i.ofs, `OFS_BUS_ERROR_FLAGS) && csr_i.wdata[`BE_STALL]))
        |=> flags_q[`BE_STALL])
        else $error("stall flag dropped");
    cmdr_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (flags_q & `BE_W1C_MASK) != 32'h0000_0000 |=> $stable(fail_cmdr_o))
        else $error("commander id moved");
    reserved_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        flags_q[31:19] == 13'h0000)
        else $error("reserved bits set");
    summary_copy_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !$past(rst_i) |-> flags_q[`BE_LOCAL_SUM] == $past(local_err_i))
        else $error("summary mismatch");
    stall_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        evt_i.stall |=> err_line_o && flags_q[`BE_STALL])
        else $error("stall not logged");
    confirm_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        evt_i.confirm |=> err_line_o ##0 flags_q[`BE_CONFIRM])
        else $error("confirm not logged");
    shared_gate_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (evt_i.shared && !is_proc && !flags_q[`BE_SHARED]) |=> !flags_q[`BE_SHARED])
        else $error("shared set off processor");
    io_dirty_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (is_io && evt_i.dirty && !flags_q[`BE_DIRTY]) |=> !flags_q[`BE_DIRTY])
        else $error("dirty set on I/O node");
    mem_ctrl_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (is_mem && !flags_q[`BE_CTRL_CHK]) |=> !flags_q[`BE_CTRL_CHK])
        else $error("ctrl on memory");
    set_wins_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (set_vec[`BE_NO_CONFIRM] && csr_i.wr && hit(csr_i.ofs, `OFS_BUS_ERROR_FLAGS) && csr_i.wdata[`BE_NO_CONFIRM])
        |=> flags_q[`BE_NO_CONFIRM])
        else $error("clear beat set");
    no_err_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (set_vec == 32'h0000_0000) |=> !err_line_o)
        else $error("spurious pulse");
    io_lock_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (is_io && evt_i.drive_err) |=> capture_lock_o ##1 capture_lock_o)
        else $error("no lock");
    io_no_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        (is_io && set_vec == (32'h0000_0001 << `BE_DRIVE_ERR)) |=> !err_line_o)
        else $error("I/O drive error pulsed");
    ident_class_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        selftest_i |=> ident_q[`ID_CLASS_PROC:`ID_CLASS_IO] == $past({is_proc, is_mem, is_io}))
        else $error("class bits wrong");

    // Main scenarios: logging, clearing, locking, clear racing a set, self-test load
    stall_cov_c: cover property (@(posedge mclk_i) evt_i.stall ##1 err_line_o);
    clear_cov_c: cover property (@(posedge mclk_i) flags_q[`BE_CONFIRM] ##1 !flags_q[`BE_CONFIRM]);
    lock_cov_c:  cover property (@(posedge mclk_i) $rose(capture_lock_o));
    race_cov_c:  cover property (@(posedge mclk_i) set_vec[`BE_NO_CONFIRM] && csr_i.wr ##1 flags_q[`BE_NO_CONFIRM]);
    load_cov_c:  cover property (@(posedge mclk_i) selftest_i ##1 !selftest_i);

endmodule

`default_nettype wire

/* hw/err_pulse.sv */
`timescale 1ns/10ps
`default_nettype none

// Turns any new-error strobe into one-cycle error line pulse
module err_pulse (
    input  wire logic mclk_i,
    input  wire logic rst_i,
    input  wire logic any_set_i,
    output var  logic err_line_o
);
    logic err_q;
    logic err_d;

    // One cycle per detection cycle
    always_comb begin
        err_d = any_set_i;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            err_q <= 1'b0;
        end else begin
            err_q <= err_d;
        end
    end

    assign err_line_o = err_q;

endmodule

`default_nettype wire

/* pkg/bus_node_params.svh */
`ifndef BUS_NODE_PARAMS_SVH
`define BUS_NODE_PARAMS_SVH

// Register offsets (byte offsets within node space)
`define OFS_NODE_IDENTITY   12'h000
`define OFS_BUS_ERROR_FLAGS 12'h040

// Node identity fields
`define ID_REV_HI           31
`define ID_REV_LO           16
`define ID_CLASS_PROC       15
`define ID_CLASS_MEM        14
`define ID_CLASS_IO         13
`define ID_CODE_HI          7
`define ID_CODE_LO          0
`define ID_RESET            32'h0000_0000

// Bus error flag positions
`define BE_LOCAL_SUM        18
`define BE_CTRL_CHK         17
`define BE_DATA_CHK         16
`define BE_DIRTY            15
`define BE_SHARED           14
`define BE_CMD_ADDR         13
`define BE_NO_CONFIRM       12
`define BE_CONFIRM          11
`define BE_STALL            10
`define BE_DRIVE_ERR        9
`define BE_W1C_MASK         32'h0003_FE00
`define BE_RESET            32'h0000_0000

`endif

/* pkg/bus_node_pkg.sv */
package bus_node_pkg;

    // CSR command from the bus commander
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] ofs;
        logic [31:0] wdata;
    } csr_req_t;

    // Raw protocol violation strobes seen by the bus monitor
    typedef struct packed {
        logic ctrl_chk;
        logic data_chk;
        logic dirty;
        logic shared;
        logic cmd_addr;
        logic no_confirm;
        logic confirm;
        logic stall;
        logic drive_err;
    } bus_evt_t;

    typedef enum logic [1:0] {
        CLASS_PROC = 2'h0,
        CLASS_MEM  = 2'h1,
        CLASS_IO   = 2'h2
    } node_class_t;

endpackage

/* verification/bus_node_error_logger_test.sv */
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench: CSR traffic and bus violations against the logger
module bus_node_error_logger_test;
    import bus_node_pkg::*;
    logic        mclk_i;
    logic        rst_i;
    node_class_t node_class_i;
    csr_req_t    csr_i;
    bus_evt_t    evt_i;
    logic [3:0]  cmdr_id_i;
    logic        local_err_i;
    logic        selftest_i;
    logic [31:0] rdata_o;
    logic        rvalid_o;
    logic        err_line_o;
    logic        capture_lock_o;
    logic [3:0]  fail_cmdr_o;
    logic [31:0] exp_q[$];
    logic [31:0] v;
    logic [3:0]  id;
    int          miscompares = 0;
    int          comparisons = 0;
    int          seed = 32'h6EA3;

    bus_node_error_logger #(.TYPE_CODE(8'h5A), .REVISION(16'h0A3C)) i_bus_node_error_logger (
        .mclk_i(mclk_i), .rst_i(rst_i), .node_class_i(node_class_i), .csr_i(csr_i),
        .evt_i(evt_i), .cmdr_id_i(cmdr_id_i), .local_err_i(local_err_i), .selftest_i(selftest_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .err_line_o(err_line_o),
        .capture_lock_o(capture_lock_o), .fail_cmdr_o(fail_cmdr_o));
    bus_peer_model i_bus_peer_model (.mclk_i(mclk_i), .evt_o(evt_i), .cmdr_id_o(cmdr_id_i));

    // 40 MHz bus clock
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Full-word command only; the node has no byte or half-word path
    task automatic csr(input logic r, input logic [11:0] ofs, input logic [31:0] d);
        @(negedge mclk_i);
        csr_i <= '{rd: r, wr: ~r, ofs: ofs, wdata: d};
        @(negedge mclk_i);
        csr_i <= '0;
    endtask

    task automatic rd(input logic [11:0] ofs, input logic [31:0] exp);
        exp_q.push_back(exp);
        csr(1'b1, ofs, 32'h0);
    endtask

    task automatic stop_test;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Each answer is matched to the oldest outstanding read note
    always @(posedge mclk_i) begin
        if (rvalid_o === 1'b1) begin
            if (exp_q.size() != 0) check(rdata_o, exp_q.pop_front());
            else check(32'h1, 32'h0);
        end
    end

    // Run needs about 120 cycles; 5000-cycle limit gives generous margin before giving up
    initial begin
        #(25 * 5000);
        miscompares++;
        stop_test();
    end

    // Main sequence
    initial begin
        rst_i = 1'b1;
        node_class_i = CLASS_PROC;
        csr_i = '0;
        local_err_i = 1'b0;
        selftest_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        rst_i <= 1'b0;
        rd(12'h040, 32'h0);
        v = $random(seed);
        csr(1'b0, 12'h000, v);
        rd(12'h000, v);
        selftest_i <= 1'b1;
        @(negedge mclk_i);
        selftest_i <= 1'b0;
        rd(12'h000, 32'h0A3C_805A);
        rd(12'h080, 32'h0);
        // Every violation kind: pulse, commander capture, flag, clear
        for (int i = 0; i < 9; i++) begin
            id = 4'($random(seed));
            i_bus_peer_model.pulse(i, id);
            check(err_line_o, 1'b1);
            check(fail_cmdr_o, id);
            @(negedge mclk_i);
            check(err_line_o, 1'b0);
            rd(12'h040, 32'h1 << (9 + i));
            csr(1'b0, 12'h040, 32'h1 << (9 + i));
        end
        // Clear racing a fresh set: hardware must win
        fork
            i_bus_peer_model.pulse(3, 4'hA);
            csr(1'b0, 12'h040, 32'h0000_1000);
        join
        rd(12'h040, 32'h0000_1000);
        v = $random(seed);
        local_err_i <= v[0];
        csr(1'b0, 12'h040, 32'hFFFF_FFFF);
        rd(12'h040, {13'h0, v[0], 18'h0});
        // Second reset as an I/O node
        rst_i <= 1'b1;
        node_class_i <= CLASS_IO;
        selftest_i <= 1'b1;
        repeat (2) @(negedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        selftest_i <= 1'b0;
        rd(12'h000, 32'h0A3C_205A);
        i_bus_peer_model.pulse(0, 4'h3);
        check(err_line_o, 1'b0);
        @(negedge mclk_i);
        check(capture_lock_o, 1'b1);
        i_bus_peer_model.pulse(6, 4'h3);
        check(err_line_o, 1'b0);
        i_bus_peer_model.pulse(5, 4'h3);
        check(err_line_o, 1'b0);
        rd(12'h040, {13'h0, v[0], 18'h200});
        // Third reset as a memory node: only common bits and dirty report
        rst_i <= 1'b1;
        node_class_i <= CLASS_MEM;
        selftest_i <= 1'b1;
        repeat (2) @(negedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        selftest_i <= 1'b0;
        rd(12'h000, 32'h0A3C_405A);
        for (int i = 3; i < 9; i++) begin
            if (i != 4 && i != 6) begin
                i_bus_peer_model.pulse(i, 4'h6);
                check(err_line_o, 1'b0);
            end
        end
        i_bus_peer_model.pulse(6, 4'h6);
        check(err_line_o, 1'b1);
        rd(12'h040, {13'h0, v[0], 18'h0_8000});
        repeat (3) @(negedge mclk_i);
        stop_test();
    end
endmodule

`default_nettype wire

/* verification/bus_peer_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Stands in for the bus monitor watching the other nodes on the shared bus
module bus_peer_model (
    input  wire logic                    mclk_i,
    output var  bus_node_pkg::bus_evt_t  evt_o,
    output var  logic [3:0]              cmdr_id_o
);
    import bus_node_pkg::*;

    // Quiet bus at start; id scrambled so a stale id is never trusted
    initial begin
        evt_o = '0;
        cmdr_id_o = 4'h5;
    end

    // One-cycle violation strobe off the falling edge, id inverted after release
    task automatic pulse(input int idx, input logic [3:0] id);
        @(negedge mclk_i);
        evt_o[idx] <= 1'b1;
        cmdr_id_o <= id;
        @(negedge mclk_i);
        evt_o <= '0;
        cmdr_id_o <= ~id;
    endtask
endmodule

`default_nettype wire
